// *** design/ues_defines.vh ***
`ifndef UES_DEFINES_VH
`define UES_DEFINES_VH

// Register byte offsets within the port configuration space
`define UES_ADDR_W          12
`define UES_OFF_CONTROL     12'h100
`define UES_OFF_IRQ_STATUS  12'h104
`define UES_OFF_IRQ_MASK    12'h108
`define UES_OFF_SEVERITY    12'h10C

// Severity register fields
`define UES_SEV_LO          14
`define UES_SEV_HI          23
`define UES_SEV_STORE_LO    16
`define UES_SEV_NUM_EVT     10
`define UES_BIT_COMPLETION_TIMEOUT_SEVERITY      14
`define UES_BIT_COMPLETER_ABORT_SEVERITY      15
`define UES_BIT_INTERNAL    22
`define UES_BIT_MCBLOCKED   23
`define UES_SEV_STORE_RST   8'h46

// Control register fields
`define UES_CTL_IERR_EN     0
`define UES_CTL_MC_DIS      1
`define UES_CTL_RST         2'h0

// Interrupt status and mask fields
`define UES_IRQ_FATAL       0
`define UES_IRQ_NONFATAL    1
`define UES_IRQ_RST         2'h0

`endif

// *** design/ues_severity_upper.v ***
// The APB slave port and the address map are this design's own decisions.
`include "ues_defines.vh"

module ues_severity_upper (
  input  wire                        clock,          // Core clock, 125 MHz
  input  wire                        rst_n,          // Power-on reset, async, active low
  input  wire                        hotReset,       // Hot, warm or link reset, sync level
  input  wire                        psel,           // APB select
  input  wire                        penable,        // APB access phase
  input  wire                        pwrite,         // APB direction, high for write
  input  wire [`UES_ADDR_W-1:0]      paddr,          // APB byte address
  input  wire [31:0]                 pwdata,         // APB write data
  output reg  [31:0]                 prdata,         // APB read data
  output reg                         pready,         // APB ready
  output reg                         pslverr,        // APB error on unmapped address
  input  wire [`UES_SEV_NUM_EVT-1:0] errorEvent,     // Error pulses for classes 14..23
  output reg                         fatalReport,    // Pulse: a fatal error is reported
  output reg                         nonFatalReport, // Pulse: a non-fatal error is reported
  output reg                         irq             // Level interrupt
);

  reg  [7:0]  sevStore;
  reg  [1:0]  control;
  reg  [1:0]  irqStatus;
  reg  [1:0]  irqMask;
  reg  [1:0]  rstSync;

  // Power-on reset: assertion is immediate, release goes through two flip-flops
  wire        rstInt_n    = rstSync[1];
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end

  wire        ierrEnable  = control[`UES_CTL_IERR_EN];
  wire        mcDisable   = control[`UES_CTL_MC_DIS];
  wire        accessPhase = psel & penable;
  wire        wrStrobe    = accessPhase & pready & pwrite;
  wire        hitControl  = (paddr == `UES_OFF_CONTROL);
  wire        hitStatus   = (paddr == `UES_OFF_IRQ_STATUS);
  wire        hitMask     = (paddr == `UES_OFF_IRQ_MASK);
  wire        hitSeverity = (paddr == `UES_OFF_SEVERITY);
  wire        hitAny      = hitControl | hitStatus | hitMask | hitSeverity;

  // Severity as seen by software and by the reporting logic
  reg  [31:0] sevView;
  always @* begin
    sevView = 32'h0000_0000;
    sevView[`UES_BIT_COMPLETION_TIMEOUT_SEVERITY] = 1'b0;
    sevView[`UES_BIT_COMPLETER_ABORT_SEVERITY] = 1'b0;
    sevView[21:16] = sevStore[5:0];
    sevView[`UES_BIT_INTERNAL] = ierrEnable ? sevStore[6] : 1'b1;
    sevView[`UES_BIT_MCBLOCKED] = mcDisable ? sevStore[7] : 1'b0;
  end

  // Next value of the stored severity bits; locked bits ignore writes
  reg  [7:0]  next_sevStore;
  always @* begin
    next_sevStore = sevStore;
    if (wrStrobe && hitSeverity) begin
      next_sevStore[5:0] = pwdata[21:16];
      if (ierrEnable) begin
        next_sevStore[6] = pwdata[`UES_BIT_INTERNAL];
      end
      if (mcDisable) begin
        next_sevStore[7] = pwdata[`UES_BIT_MCBLOCKED];
      end
    end
  end

  // Classify incoming errors by their current severity
  wire [`UES_SEV_NUM_EVT-1:0] sevSlice = sevView[`UES_SEV_HI:`UES_SEV_LO];
  wire anyFatal    = |(errorEvent & sevSlice);
  wire anyNonFatal = |(errorEvent & ~sevSlice);

  // Interrupt status: a new event wins over a write-one-to-clear
  reg  [1:0]  next_irqStatus;
  always @* begin
    next_irqStatus = irqStatus;
    if (wrStrobe && hitStatus) begin
      next_irqStatus = irqStatus & ~pwdata[1:0];
    end
    if (anyFatal) begin
      next_irqStatus[`UES_IRQ_FATAL] = 1'b1;
    end
    if (anyNonFatal) begin
      next_irqStatus[`UES_IRQ_NONFATAL] = 1'b1;
    end
  end

  reg  [1:0]  next_irqMask;
  always @* begin
    next_irqMask = irqMask;
    if (wrStrobe && hitMask) begin
      next_irqMask = pwdata[1:0];
    end
  end

  reg  [1:0]  next_control;
  always @* begin
    next_control = control;
    if (wrStrobe && hitControl) begin
      next_control = pwdata[1:0];
    end
  end

  // Read multiplexer
  reg  [31:0] readValue;
  always @* begin
    readValue = 32'h0000_0000;
    if (hitControl) begin
      readValue = {30'h0000_0000, control};
    end else if (hitStatus) begin
      readValue = {30'h0000_0000, irqStatus};
    end else if (hitMask) begin
      readValue = {30'h0000_0000, irqMask};
    end else if (hitSeverity) begin
      readValue = sevView;
    end
  end

  // Sticky severity bits: only the power-on reset returns them to default
  always @(posedge clock or negedge rstInt_n) begin
    if (!rstInt_n) begin
      sevStore <= `UES_SEV_STORE_RST;
    end else begin
      sevStore <= next_sevStore;
    end
  end

  // Non-sticky state, cleared by either reset
  always @(posedge clock or negedge rstInt_n) begin
    if (!rstInt_n) begin
      control        <= `UES_CTL_RST;
      irqStatus      <= `UES_IRQ_RST;
      irqMask        <= `UES_IRQ_RST;
      irq            <= 1'b0;
      fatalReport    <= 1'b0;
      nonFatalReport <= 1'b0;
    end else if (hotReset) begin
      control        <= `UES_CTL_RST;
      irqStatus      <= `UES_IRQ_RST;
      irqMask        <= `UES_IRQ_RST;
      irq            <= 1'b0;
      fatalReport    <= 1'b0;
      nonFatalReport <= 1'b0;
    end else begin
      control        <= next_control;
      irqStatus      <= next_irqStatus;
      irqMask        <= next_irqMask;
      irq            <= |(next_irqStatus & next_irqMask);
      fatalReport    <= anyFatal;
      nonFatalReport <= anyNonFatal;
    end
  end

  // APB slave: one wait state, ready in the second access cycle
  always @(posedge clock or negedge rstInt_n) begin
    if (!rstInt_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= accessPhase & ~pready;
      pslverr <= accessPhase & ~pready & ~hitAny;
      if (accessPhase && !pready && !pwrite) begin
        prdata <= readValue;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule

// *** verification/ues_severity_upper_props.sv ***
module ues_severity_upper_props (
  input wire logic        clock, rst_n, hotReset, psel, penable, pwrite,
  input wire logic        pready, pslverr, fatalReport, nonFatalReport, irq,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic [9:0]  errorEvent
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no ready after one wait state");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
  chk_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  chk_sev_fixed: assert property (
    pready && !pwrite && paddr == 12'h10C |-> prdata[15:0] == 0 && prdata[31:24] == 0)
    else $error("fixed severity bits not zero");
  chk_ro_nonfatal: assert property (
    (|errorEvent[1:0]) && !hotReset |=> nonFatalReport) else $error("class 14/15 not non-fatal");
  chk_event_report: assert property (
    (|errorEvent) && !hotReset |=> fatalReport || nonFatalReport) else $error("event unreported");
  chk_report_cause: assert property (
    fatalReport || nonFatalReport |-> $past(|errorEvent)) else $error("report without event");
  chk_hot_quiet: assert property (hotReset |=> !irq && !fatalReport && !nonFatalReport)
    else $error("outputs active after hot reset");
  cover property (fatalReport);
  cover property (nonFatalReport);
  cover property (pslverr);
  cover property (irq);
endmodule

bind ues_severity_upper ues_severity_upper_props ues_severity_upper_props_inst (.clock, .rst_n,
  .hotReset, .psel, .penable, .pwrite, .pready, .pslverr, .fatalReport, .nonFatalReport, .irq,
  .paddr, .prdata, .errorEvent);

// *** verification/tb_ues_severity_upper.sv ***
module tb_ues_severity_upper;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin nTests++; if ((g) !== (e)) begin nErrors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
  logic        clock = 0, rst_n = 0, hotReset = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, fatalReport, nonFatalReport, irq, er;
  logic [9:0]  errorEvent = 0;
  int          nErrors = 0, nTests = 0;
  ues_severity_upper ues_severity_upper_inst (.clock, .rst_n, .hotReset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .errorEvent, .fatalReport,
    .nonFatalReport, .irq);
  initial forever #4 clock = ~clock;
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock) penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clock);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    xf(0, a, 0);
    `CHK(rd, e)
  endtask
  task automatic ev(input int i, input logic f);
    errorEvent <= 10'h001 << i;
    @(posedge clock) errorEvent <= 0;
    @(posedge clock) `CHK({fatalReport, nonFatalReport}, {f, !f})
  endtask
  task tDefaults;
    rdc(12'h10C, 32'h0046_0000);
    xf(0, 12'h0FC, 0);
    `CHK({er, rd}, {1'b1, 32'h0000_0000})
    $display("defaults done");
  endtask
  task tLocks;
    xf(1, 12'h100, 3);
    xf(1, 12'h10C, 32'hFFFF_FFFF);
    rdc(12'h10C, 32'h00FF_0000);
    xf(1, 12'h100, 0);
    rdc(12'h10C, 32'h007F_0000);
    xf(1, 12'h10C, 0);
    xf(1, 12'h100, 3);
    rdc(12'h10C, 32'h00C0_0000);
    $display("locks done");
  endtask
  task tEvents(input logic [31:0] s);
    xf(1, 12'h10C, s);
    for (int i = 0; i < 10; i++) ev(i, i > 1 && s[14+i]);
    $display("events done");
  endtask
  task tIrq;
    xf(1, 12'h108, 1);
    ev(3, 1);
    `CHK(irq, 1'b1)
    rdc(12'h104, 3);
    xf(1, 12'h108, 0);
    repeat (2) @(posedge clock);
    `CHK(irq, 1'b0)
    xf(1, 12'h108, 1);
    repeat (2) @(posedge clock);
    `CHK(irq, 1'b1)
    xf(1, 12'h104, 3);
    repeat (2) @(posedge clock);
    `CHK(irq, 1'b0)
    rdc(12'h104, 0);
    $display("irq done");
  endtask
  task tHot;
    hotReset <= 1;
    @(posedge clock) hotReset <= 0;
    @(posedge clock);
    rdc(12'h10C, 32'h006A_0000);
    ev(8, 1);
    ev(9, 0);
    rst_n <= 0;
    repeat (2) @(posedge clock);
    rst_n <= 1;
    @(posedge clock);
    rdc(12'h10C, 32'h0046_0000);
    $display("hot reset done");
  endtask
  task tallyAndFinish;
    $display("tests=%0d errors=%0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1;
    @(posedge clock);
    tDefaults;
    tLocks;
    tEvents(32'h0055_0000);
    tEvents(32'h00AA_0000);
    tIrq;
    tHot;
    tallyAndFinish;
  end
  initial begin
    repeat (3000) @(posedge clock);
    nErrors++;
    tallyAndFinish;
  end
endmodule
